// ===== src/fbcp_params.svh
// constants for the framebuffer colour packer
`ifndef FBCP_PARAMS_SVH
`define FBCP_PARAMS_SVH
`define FBCP_ADDR_CTRL      32'h0000_0000
`define FBCP_ADDR_SOFTMASK  32'h0000_0004
`define FBCP_ADDR_HARDMASK  32'h0000_0008
`define FBCP_ADDR_FILL      32'h0000_000C
`define FBCP_ADDR_STATUS    32'h0000_0010
`define FBCP_CTRL_FMT_LSB   0
`define FBCP_CTRL_ORDER     4
`define FBCP_CTRL_COLOR_EN  5
`define FBCP_CTRL_NOALPHA   6
`define FBCP_CTRL_SRC_FETCH 7
`define FBCP_CTRL_DST_FETCH 8
`define FBCP_CTRL_FILL_EN   9
`define FBCP_CTRL_RESET     32'h0000_0020
`define FBCP_MASK_RESET     32'hFFFF_FFFF
`define FBCP_ALPHA_FULL     8'hFF
`endif

// ===== src/fbcp_pkg.sv
// types for the framebuffer colour packer
package fbcp_pkg;
  typedef enum logic [3:0] {
    FBCP_IDLE  = 4'b0001,
    FBCP_FETCH = 4'b0010,
    FBCP_MERGE = 4'b0100,
    FBCP_WRITE = 4'b1000
  } fbcp_state_t;
endpackage

// ===== src/fbcp_packer.sv
// framebuffer colour packer with axi4-lite control registers
`timescale 1ns/10ps
`include "fbcp_params.svh"
module fbcp_packer
  import fbcp_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              pix_valid,
  output logic                   pix_ready,
  input  wire logic [31:0]       pix_color,
  input  wire logic              pix_trapezoid,
  output logic                   fb_rd_req,
  input  wire logic              fb_rd_ack,
  input  wire logic [31:0]       fb_rd_data,
  output logic                   fb_wr_en,
  output logic [31:0]            fb_wr_data,
  output logic [31:0]            fb_hard_mask,
  output logic [31:0]            fb_unpacked
);
  initial begin
    if (ADDR_W < 8) $error("ADDR_W too small");
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [31:0] ctrl, soft_mask, hard_mask, fill_value;
  logic [31:0] aw_addr, w_data;
  logic [3:0]  w_strb;
  logic        aw_held, w_held, fmt_bad;
  fbcp_state_t state, next_state;
  logic [3:0]  fmt;
  logic        order_rgb, color_en, alpha_absent_flag;
  logic        dest_fetch_enable, block_fill_enable;

  assign fmt               = ctrl[`FBCP_CTRL_FMT_LSB +: 4];
  assign order_rgb         = ctrl[`FBCP_CTRL_ORDER];
  assign color_en          = ctrl[`FBCP_CTRL_COLOR_EN];
  assign alpha_absent_flag = ctrl[`FBCP_CTRL_NOALPHA];
  assign dest_fetch_enable = ctrl[`FBCP_CTRL_DST_FETCH];
  assign block_fill_enable = ctrl[`FBCP_CTRL_FILL_EN];
  assign fb_hard_mask      = hard_mask;
  assign s_axi_awready     = !aw_held && !s_axi_bvalid;
  assign s_axi_wready      = !w_held && !s_axi_bvalid;
  assign s_axi_arready     = !s_axi_rvalid;
  assign s_axi_bresp       = 2'b00;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // address and data may arrive in either order
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= 32'(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // register update and write response
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl         <= `FBCP_CTRL_RESET;
      soft_mask    <= `FBCP_MASK_RESET;
      hard_mask    <= `FBCP_MASK_RESET;
      fill_value   <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (aw_held && w_held) begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr[7:0])
          8'(`FBCP_ADDR_CTRL):
            ctrl <= merge_bytes(ctrl, w_data, w_strb) & 32'h0000_03FF;
          8'(`FBCP_ADDR_SOFTMASK):
            soft_mask <= merge_bytes(soft_mask, w_data, w_strb);
          8'(`FBCP_ADDR_HARDMASK):
            hard_mask <= merge_bytes(hard_mask, w_data, w_strb);
          8'(`FBCP_ADDR_FILL):
            fill_value <= merge_bytes(fill_value, w_data, w_strb);
          default: ;
        endcase
      end
    end
  end

  // read channel, unmapped reads return zero with okay
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr[7:0])
        8'(`FBCP_ADDR_CTRL):     s_axi_rdata <= ctrl;
        8'(`FBCP_ADDR_SOFTMASK): s_axi_rdata <= soft_mask;
        8'(`FBCP_ADDR_HARDMASK): s_axi_rdata <= hard_mask;
        8'(`FBCP_ADDR_FILL):     s_axi_rdata <= fill_value;
        8'(`FBCP_ADDR_STATUS):
          s_axi_rdata <= {27'h0, fmt_bad, state};
        default:                 s_axi_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // pack and unpack
  // ------------------------------------------------------------
  // fields come from the top bits of each 8-bit channel
  function automatic logic [31:0] pack(input logic [31:0] c,
                                       input logic [3:0]  f,
                                       input logic        rgb);
    logic [7:0]  r, g, b, a, lo, hi;
    logic [31:0] p;
    r = c[7:0];
    g = c[15:8];
    b = c[23:16];
    a = c[31:24];
    lo = rgb ? b : r;
    hi = rgb ? r : b;
    p = 32'h0000_0000;
    case (f)
      4'd0: p = {a, hi, g, lo};
      4'd1: p = {12'h0, a[7:3], hi[7:3], g[7:3], lo[7:3]};
      4'd2: p = {16'h0, a[7:4], hi[7:4], g[7:4], lo[7:4]};
      4'd3, 4'd4: begin
        p = {a[7:4], a[7:4], hi[7:4], hi[7:4],
             g[7:4], g[7:4], lo[7:4], lo[7:4]};
      end
      4'd5, 4'd6: begin
        if (rgb) p[7:0] = {r[7:5], g[7:5], b[7:6]};
        else     p[7:0] = {b[7:6], g[7:5], r[7:5]};
        p[15:8] = p[7:0];
      end
      4'd7, 4'd8: begin
        p[3:0] = {hi[7], g[7:6], lo[7]};
        p[7:4] = p[3:0];
      end
      4'd13: p = {1'b0, hi[7:3], g[7:3], lo[7:3], 16'h0};
      4'd14: p = {24'h0, r};
      4'd15: p = {28'h0, r[7:4]};
      default: p = 32'h0000_0000;
    endcase
    return p;
  endfunction

  // scale a field of n top bits by bit replication
  function automatic logic [7:0] widen(input logic [7:0] v,
                                       input int n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) r[7-i] = v[7 - (i % n)];
    return r;
  endfunction

  function automatic logic [31:0] unpack(input logic [31:0] p,
                                         input logic [3:0]  f,
                                         input logic        rgb,
                                         input logic        noa);
    logic [7:0] lo, g, hi, a;
    logic [31:0] u;
    lo = 8'h00; g = 8'h00; hi = 8'h00; a = `FBCP_ALPHA_FULL;
    case (f)
      4'd0: begin lo = p[7:0]; g = p[15:8]; hi = p[23:16]; a = p[31:24]; end
      4'd1: begin
        lo = widen({p[4:0], 3'b0}, 5);  g = widen({p[9:5], 3'b0}, 5);
        hi = widen({p[14:10], 3'b0}, 5); a = widen({p[19:15], 3'b0}, 5);
      end
      4'd2: begin
        lo = widen({p[3:0], 4'b0}, 4);  g = widen({p[7:4], 4'b0}, 4);
        hi = widen({p[11:8], 4'b0}, 4); a = widen({p[15:12], 4'b0}, 4);
      end
      4'd3, 4'd4: begin
        lo = widen({p[3:0], 4'b0}, 4);   g = widen({p[11:8], 4'b0}, 4);
        hi = widen({p[19:16], 4'b0}, 4); a = widen({p[27:24], 4'b0}, 4);
      end
      4'd5, 4'd6: begin
        if (rgb) begin
          lo = widen({p[7:5], 5'b0}, 3); g = widen({p[4:2], 5'b0}, 3);
          hi = widen({p[1:0], 6'b0}, 2);
        end else begin
          lo = widen({p[2:0], 5'b0}, 3); g = widen({p[5:3], 5'b0}, 3);
          hi = widen({p[7:6], 6'b0}, 2);
        end
      end
      4'd7, 4'd8: begin
        lo = widen({p[0], 7'b0}, 1); g = widen({p[2:1], 6'b0}, 2);
        hi = widen({p[3], 7'b0}, 1);
      end
      4'd13: begin
        lo = widen({p[20:16], 3'b0}, 5); g = widen({p[25:21], 3'b0}, 5);
        hi = widen({p[30:26], 3'b0}, 5);
      end
      4'd14, 4'd15: begin
        lo = (f == 4'd14) ? p[7:0] : {p[3:0], 4'b0};
        g = lo; hi = lo; a = lo;
      end
      default: ;
    endcase
    if (f >= 4'd14) u = {a, hi, g, lo};
    else if (rgb && f != 4'd5 && f != 4'd6) u = {a, lo, g, hi};
    else u = {a, hi, g, lo};
    if (noa) u[31:24] = `FBCP_ALPHA_FULL;
    return u;
  endfunction

  // ------------------------------------------------------------
  // pixel pipeline
  // ------------------------------------------------------------
  logic [31:0] pend_color, packed_px, pack_src;
  logic        pend_fill, fill_now;
  assign fill_now  = pix_trapezoid && block_fill_enable;
  assign pix_ready = (state == FBCP_IDLE);
  assign fb_rd_req = (state == FBCP_FETCH);
  // with no alpha planes and colour packing on, the stored alpha is forced to full
  assign pack_src  = {alpha_absent_flag ? `FBCP_ALPHA_FULL
                                        : pend_color[31:24],
                      pend_color[23:0]};
  assign packed_px = color_en ? pack(pack_src, fmt, order_rgb)
                              : pend_color;

  always_comb begin
    next_state = state;
    case (state)
      FBCP_IDLE:
        if (pix_valid)
          next_state = (dest_fetch_enable && !fill_now) ? FBCP_FETCH
                                                        : FBCP_WRITE;
      FBCP_FETCH: if (fb_rd_ack) next_state = FBCP_MERGE;
      FBCP_MERGE: next_state = FBCP_WRITE;
      FBCP_WRITE: next_state = FBCP_IDLE;
      default:    next_state = FBCP_IDLE;
    endcase
  end

  // state and captured pixel
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= FBCP_IDLE;
      pend_color <= 32'h0000_0000;
      pend_fill  <= 1'b0;
      fmt_bad    <= 1'b0;
    end else begin
      state <= next_state;
      if (state == FBCP_IDLE && pix_valid) begin
        pend_color <= pix_color;
        pend_fill  <= fill_now;
        fmt_bad    <= color_en && fmt > 4'd8 && fmt < 4'd13;
      end
    end
  end

  // framebuffer data; the fill skips all colour work
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fb_wr_en    <= 1'b0;
      fb_wr_data  <= 32'h0000_0000;
      fb_unpacked <= 32'h0000_0000;
    end else begin
      fb_wr_en <= 1'b0;
      if (state == FBCP_FETCH && fb_rd_ack) begin
        fb_unpacked <= unpack(fb_rd_data, fmt, order_rgb,
                              alpha_absent_flag);
        fb_wr_data  <= fb_rd_data;
      end
      if (state == FBCP_WRITE) begin
        fb_wr_en <= 1'b1;
        if (pend_fill)
          fb_wr_data <= fill_value;
        else if (dest_fetch_enable)
          fb_wr_data <= (packed_px & soft_mask)
                      | (fb_wr_data & ~soft_mask);
        else
          fb_wr_data <= packed_px & soft_mask;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_fill_value;
    @(posedge sys_clk) disable iff (!rst_b)
      (state == FBCP_WRITE && pend_fill) |=> (fb_wr_data == $past(fill_value));
  endproperty
  a_fill_value: assert property (p_fill_value)
    else $error("fill value not written");

  property p_fill_no_fetch;
    @(posedge sys_clk) disable iff (!rst_b)
      (state == FBCP_IDLE && pix_valid && fill_now) |=> state == FBCP_WRITE;
  endproperty
  a_fill_no_fetch: assert property (p_fill_no_fetch)
    else $error("block fill read the framebuffer");

  property p_fetch_then_write;
    @(posedge sys_clk) disable iff (!rst_b)
      (state == FBCP_FETCH && fb_rd_ack) |=> ##1 state == FBCP_WRITE ##1 fb_wr_en;
  endproperty
  a_fetch_then_write: assert property (p_fetch_then_write)
    else $error("merge did not write back");

  property p_hw_mask_out;
    @(posedge sys_clk) disable iff (!rst_b) fb_hard_mask == hard_mask;
  endproperty
  a_hw_mask_out: assert property (p_hw_mask_out)
    else $error("hardware mask not driven");

  property p_write_pulse;
    @(posedge sys_clk) disable iff (!rst_b)
      fb_wr_en |-> $past(state) == FBCP_WRITE;
  endproperty
  a_write_pulse: assert property (p_write_pulse)
    else $error("write strobe without write state");

  property p_raw_pass;
    @(posedge sys_clk) disable iff (!rst_b)
      (state == FBCP_WRITE && !pend_fill && !color_en && !dest_fetch_enable)
        |=> fb_wr_data == ($past(pend_color) & $past(soft_mask));
  endproperty
  a_raw_pass: assert property (p_raw_pass)
    else $error("raw write altered");

  property p_fmt0_bgr;
    @(posedge sys_clk) disable iff (!rst_b)
      (color_en && fmt == 4'd0 && !order_rgb)
        |-> packed_px == {alpha_absent_flag ? 8'hFF : pend_color[31:24],
                          pend_color[23:0]};
  endproperty
  a_fmt0_bgr: assert property (p_fmt0_bgr)
    else $error("format 0 bgr packing wrong");

  property p_front_back;
    @(posedge sys_clk) disable iff (!rst_b)
      (color_en && (fmt == 4'd5 || fmt == 4'd6))
        |-> packed_px[7:0] == packed_px[15:8];
  endproperty
  a_front_back: assert property (p_front_back)
    else $error("front and back copies differ");

  property p_fetch_req;
    @(posedge sys_clk) disable iff (!rst_b)
      (state == FBCP_IDLE && pix_valid && dest_fetch_enable && !fill_now)
        |=> fb_rd_req;
  endproperty
  a_fetch_req: assert property (p_fetch_req)
    else $error("dest fetch not requested");

endmodule // fbcp_packer

// ===== dv/fbcp_vram_model.sv
// behavioural framebuffer memory word facing the colour packer
`timescale 1ns/10ps
module fbcp_vram_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  rd_delay,
  input  wire logic        fb_rd_req,
  output logic             fb_rd_ack,
  output logic [31:0]      fb_rd_data,
  input  wire logic        fb_wr_en,
  input  wire logic [31:0] fb_wr_data,
  input  wire logic [31:0] fb_hard_mask,
  output logic [31:0]      mem_word,
  output logic [7:0]       rd_count
);
  logic [3:0] wait_cnt;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // memory planes outside the hard mask keep their old contents
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_word <= 32'h0000_0000;
    end else if (fb_wr_en) begin
      mem_word <= (mem_word & ~fb_hard_mask) | (fb_wr_data & fb_hard_mask);
    end
  end

  // read answered rd_delay+1 cycles after the request; data line toggles when not valid
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fb_rd_ack  <= 1'b0;
      fb_rd_data <= 32'h0000_0000;
      wait_cnt   <= 4'h0;
      rd_count   <= 8'h00;
    end else if (fb_rd_req && !fb_rd_ack && wait_cnt == rd_delay) begin
      fb_rd_ack  <= 1'b1;
      fb_rd_data <= mem_word;
      wait_cnt   <= 4'h0;
      rd_count   <= rd_count + 8'h01;
    end else begin
      fb_rd_ack  <= 1'b0;
      fb_rd_data <= ~fb_rd_data;
      if (fb_rd_req && !fb_rd_ack) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule // fbcp_vram_model

// ===== dv/tb_framebuffer_color_packer.sv
// self-checking bench for the framebuffer colour packer
`timescale 1ns/10ps
`include "fbcp_params.svh"
module tb_framebuffer_color_packer;
  localparam logic [5:0] RGB = 6'h01, COL = 6'h02, NOA = 6'h04;
  localparam logic [5:0] DST = 6'h10, FIL = 6'h20;
  logic        sys_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, pix_valid, pix_trapezoid;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, pix_ready, fb_rd_req, fb_rd_ack, fb_wr_en;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb, rd_delay;
  logic [7:0]  rd_count;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [31:0] pix_color, fb_rd_data, fb_wr_data, fb_hard_mask;
  logic [31:0] fb_unpacked, mem_word, wd, rv;
  int          mismatches, checks, cycles;

  fbcp_packer uut (.sys_clk(sys_clk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_color(pix_color),
    .pix_trapezoid(pix_trapezoid), .fb_rd_req(fb_rd_req),
    .fb_rd_ack(fb_rd_ack), .fb_rd_data(fb_rd_data), .fb_wr_en(fb_wr_en),
    .fb_wr_data(fb_wr_data), .fb_hard_mask(fb_hard_mask),
    .fb_unpacked(fb_unpacked));

  fbcp_vram_model vram (.sys_clk(sys_clk), .rst_b(rst_b),
    .rd_delay(rd_delay), .fb_rd_req(fb_rd_req), .fb_rd_ack(fb_rd_ack),
    .fb_rd_data(fb_rd_data), .fb_wr_en(fb_wr_en),
    .fb_wr_data(fb_wr_data), .fb_hard_mask(fb_hard_mask),
    .mem_word(mem_word), .rd_count(rd_count));

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  always #10 sys_clk = ~sys_clk;

  // cut a hang short well beyond the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // take the top n bits of a channel and place them at bit m
  function automatic logic [31:0] fld(input logic [7:0] v, input int n,
                                      input int m);
    return (32'(v) >> (8 - n)) << m;
  endfunction

  // expected packed word; front/back pairs fill both positions
  function automatic logic [31:0] pack(input logic [3:0] f, input logic o,
                                       input logic noa, input logic [31:0] c);
    logic [7:0]  r, g, b, a;
    logic [31:0] x;
    {a, b, g, r} = c;
    if (noa) a = 8'hFF;
    if (o && f != 4'h5 && f != 4'h6 && f < 4'hE) {r, b} = {b, r};
    case (f)
      4'h0: x = fld(r,8,0) | fld(g,8,8) | fld(b,8,16) | fld(a,8,24);
      4'h1: x = fld(r,5,0) | fld(g,5,5) | fld(b,5,10) | fld(a,5,15);
      4'h2: x = fld(r,4,0) | fld(g,4,4) | fld(b,4,8) | fld(a,4,12);
      4'h3, 4'h4: x = (fld(r,4,0) | fld(g,4,8) | fld(b,4,16)
                       | fld(a,4,24)) * 32'h0000_0011;
      4'h5, 4'h6: x = (o ? fld(r,3,5) | fld(g,3,2) | fld(b,2,0)
                         : fld(r,3,0) | fld(g,3,3) | fld(b,2,6))
                      * 32'h0000_0101;
      4'h7, 4'h8: x = (fld(r,1,0) | fld(g,2,1) | fld(b,1,3)) * 32'h0000_0011;
      4'hD: x = fld(r,5,16) | fld(g,5,21) | fld(b,5,26);
      4'hE: x = fld(r,8,0);
      4'hF: x = fld(r,4,0);
      default: x = 32'h0000_0000;
    endcase
    return x;
  endfunction

  // ----------------------------------------------------------------
  // bus and pixel drivers
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    logic aw_p, w_p, aw_t, w_t;
    aw_p = 1'b1;
    w_p = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_p || w_p) begin
      @(negedge sys_clk);
      aw_t = s_axi_awready;
      w_t = s_axi_wready;
      @(posedge sys_clk);
      if (aw_p && aw_t) begin
        s_axi_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && w_t) begin
        s_axi_wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    do begin
      @(negedge sys_clk);
      aw_t = s_axi_bvalid;
      @(posedge sys_clk);
    end while (aw_t !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
    logic t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      t = s_axi_arready;
      @(posedge sys_clk);
    end while (t !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge sys_clk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      @(posedge sys_clk);
    end while (t !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic ctl(input logic [3:0] f, input logic [5:0] fl);
    reg_wr(`FBCP_ADDR_CTRL, {22'h0, fl, f});
  endtask

  // offer one pixel and collect the framebuffer write it causes
  task automatic send(input logic [31:0] c, input logic trap);
    logic t;
    pix_color <= c;
    pix_trapezoid <= trap;
    pix_valid <= 1'b1;
    do begin
      @(negedge sys_clk);
      t = pix_ready;
      @(posedge sys_clk);
    end while (t !== 1'b1);
    pix_valid <= 1'b0;
    do begin
      @(negedge sys_clk);
      t = fb_wr_en;
      wd = fb_wr_data;
      @(posedge sys_clk);
    end while (t !== 1'b1);
    // let the memory word settle before anyone looks at it
    @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] ea [6] = '{32'h0000_0020, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
                            32'h0000_0000, 32'h0000_0001, 32'h0000_0000};
    for (int i = 0; i < 6; i++) begin
      reg_rd(32'(i * 4), rv);
      chk("register reset value", ea[i], rv);
    end
    s_axi_wstrb <= 4'h3;
    reg_wr(`FBCP_ADDR_FILL, 32'hFFFF_FFFF);
    s_axi_wstrb <= 4'hF;
    reg_rd(`FBCP_ADDR_FILL, rv);
    chk("byte strobe write", 32'h0000_FFFF, rv);
    chk("responses okay", 32'h0000_0000, {28'h0, s_axi_bresp, s_axi_rresp});
    $display("test reset done");
  endtask

  task automatic t_pack;
    logic [3:0] fl [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                            4'h7, 4'h8, 4'hD, 4'hE, 4'hF};
    for (int i = 0; i < 24; i++) begin
      ctl(fl[i / 2], COL | ((i % 2 == 1) ? RGB : 6'h00));
      send(32'h9C3A_E571, 1'b0);
      chk("packed word", pack(fl[i / 2], 1'(i % 2), 1'b0, 32'h9C3A_E571), wd);
    end
    ctl(4'h0, COL | NOA);
    send(32'h1122_3344, 1'b0);
    chk("alpha absent", pack(4'h0, 1'b0, 1'b1, 32'h1122_3344), wd);
    ctl(4'h0, 6'h00);
    send(32'h5A5A_0FF0, 1'b0);
    chk("raw passthrough", 32'h5A5A_0FF0, wd);
    for (int f = 9; f < 13; f++) begin
      ctl(4'(f), COL);
      send(32'h9C3A_E571, 1'b0);
      chk("unsupported format data", 32'h0000_0000, wd);
      reg_rd(`FBCP_ADDR_STATUS, rv);
      chk("unsupported format flag", 32'h0000_0001, {31'h0, rv[4]});
    end
    $display("test pack done");
  endtask

  task automatic t_masks;
    logic [7:0] r0;
    ctl(4'h0, 6'h00);
    send(32'h1234_5678, 1'b0);
    reg_wr(`FBCP_ADDR_HARDMASK, 32'h0000_FFFF);
    r0 = rd_count;
    send(32'hAABB_CCDD, 1'b0);
    chk("hard mask port", 32'h0000_FFFF, fb_hard_mask);
    chk("hard masked memory", 32'h1234_CCDD, mem_word);
    chk("reads under hard mask", 32'(r0), 32'(rd_count));
    reg_wr(`FBCP_ADDR_FILL, 32'hCAFE_F00D);
    ctl(4'h0, COL | FIL | RGB);
    send(32'h9C3A_E571, 1'b1);
    chk("fill data", 32'hCAFE_F00D, wd);
    chk("fill under hard mask", 32'h1234_F00D, mem_word);
    send(32'h9C3A_E571, 1'b0);
    chk("fill needs trapezoid", pack(4'h0, 1'b1, 1'b0, 32'h9C3A_E571), wd);
    reg_wr(`FBCP_ADDR_HARDMASK, 32'hFFFF_FFFF);
    ctl(4'h0, 6'h00);
    send(32'h1234_5678, 1'b0);
    rd_delay <= 4'h3;
    reg_wr(`FBCP_ADDR_SOFTMASK, 32'h00FF_00FF);
    ctl(4'h0, DST);
    r0 = rd_count;
    send(32'hAABB_CCDD, 1'b0);
    chk("soft mask merge", 32'h12BB_56DD, wd);
    chk("one read per pixel", 32'(r0 + 8'h01), 32'(rd_count));
    reg_wr(`FBCP_ADDR_SOFTMASK, 32'hFFFF_FFFF);
    $display("test masks done");
  endtask

  task automatic t_unpack;
    logic [31:0] st [4] = '{32'h0000_C03F, 32'h0000_0005, 32'h0000_00A5,
                            32'h8040_2010};
    logic [3:0]  fm [4] = '{4'h1, 4'hF, 4'hE, 4'h0};
    logic [31:0] ex [4] = '{32'h0884_08FF, 32'h5050_5050, 32'hA5A5_A5A5,
                            32'h8040_2010};
    for (int i = 0; i < 4; i++) begin
      rd_delay <= 4'(i);
      ctl(4'h0, 6'h00);
      send(st[i], 1'b0);
      ctl(fm[i], COL | DST);
      send(32'h0000_0000, 1'b0);
      chk("unpacked read", ex[i], fb_unpacked);
    end
    $display("test unpack done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, pix_valid, pix_trapezoid} = 3'h0;
    s_axi_awaddr = 32'h0000_0000;
    s_axi_araddr = 32'h0000_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    pix_color = 32'h0000_0000;
    rd_delay = 4'h0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_pack();
    t_masks();
    t_unpack();
    final_report();
  end
endmodule // tb_framebuffer_color_packer
